// [logic/bdsc_top.v]
// Purpose: full-bridge drive controller, direct or self-switching
// Assumes: ref_clk 100 MHz, all control pins asynchronous
// Notes: oscillator runs from divided ref_clk via tap table
//
// Summary of operation
// RULE1 - With enable high, drive-source select picks direct or self-switching mode.
// RULE2 - Direct mode passes both gate inputs to the bridge gate drivers.
// RULE3 - Each bridge leg inserts a short dead time between its switches.
// RULE4 - Short direct-mode gate pulses still change the bridge state.
// RULE5 - Self mode: input a is step strobe, input b step direction.
// RULE6 - Entering self mode starts the oscillator at 175 kHz.
// RULE7 - Rate echo follows switching frequency, 50% duty, rising with node a.
// RULE8 - Frequency mode, direction low: each strobe raises frequency one tap.
// RULE9 - Frequency mode, direction high: each strobe lowers frequency one tap.
// RULE10 - Duty adjustment applies at the 205 kHz top tap with duty select high.
// RULE11 - Duty adjustment also entered at any tap when duty select rises.
// RULE12 - Duty mode, direction low: strobe lowers duty one step.
// RULE13 - Decrease strobes ignored at the 10% minimum duty.
// RULE14 - Duty mode, direction high: strobe raises duty one step.
// RULE15 - Increase strobes ignored at the 50% maximum duty.
// RULE16 - Frequency stepping resumes only at 50% duty with duty select low.
// RULE17 - Frequency confined to 110 kHz through 205 kHz taps.
// RULE18 - Duty held at 50% while frequency stepping.
// RULE19 - Taps and duty steps come from fixed parameterised tables.
// RULE20 - Enable low holds all switches off and ignores strobes.
`timescale 1ns/1ps
`include "bdsc_consts.vh"
module bdsc_top #(
  parameter NTAPS = `BDSC_NTAPS,
  parameter F_MIN_HZ = `BDSC_F_MIN_HZ,
  parameter TAP_STEP_HZ = `BDSC_TAP_STEP_HZ,
  parameter DUTY_STEP = `BDSC_DUTY_STEP
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Control pins from the controller
  input wire enable,
  input wire drive_source_sel,
  input wire duty_adjust_sel,
  input wire gate_input_a,
  input wire gate_input_b,
  // Bridge gate drives
  output wire bridge_a_high,
  output wire bridge_a_low,
  output wire bridge_b_high,
  output wire bridge_b_low,
  // Rate echo
  output reg rate_echo
);
  localparam DEAD_RAW = `BDSC_DEAD_CYC;
  localparam DEAD_CYC = (DEAD_RAW < 1) ? 1 : DEAD_RAW;
  localparam START_TAP = (`BDSC_F_START_HZ - F_MIN_HZ) / TAP_STEP_HZ;
  localparam TOP_TAP = NTAPS - 1;
  // Duty limits at register width so no assignment drops bits
  localparam [6:0] DUTY_MAX = `BDSC_DUTY_MAX;
  localparam [6:0] DUTY_MIN = `BDSC_DUTY_MIN;
  localparam [6:0] DUTY_INC = DUTY_STEP;
  // Echo lag: mux flop, leg change, dead count, switch flop
  localparam ECHO_LAG = DEAD_CYC + 3;
  // Mode states
  localparam ST_OFF = 2'h0;
  localparam ST_DIRECT = 2'h1;
  localparam ST_FREQ = 2'h2;
  localparam ST_DUTY = 2'h3;

  wire en_s;
  wire src_s;
  wire duty_s;
  wire a_s;
  wire b_s;
  wire a_rise;
  wire duty_rise;
  // Decoded mode and step strobes
  wire self_mode;
  wire leg_enable;
  wire enter_self;
  wire freq_move;
  wire duty_move;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [4:0] tap;
  reg [6:0] duty;
  reg [15:0] phase;
  reg node_a;
  reg node_b;
  reg drive_a;
  reg drive_b;
  // Echo delay line, one stage per cycle of drive lag
  reg [ECHO_LAG-1:0] echo_pipe;

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // Every control pin is asynchronous; two flops before any logic
  // Enable pin
  bdsc_edge_sync u_en (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pin(enable),
    .level(en_s),
    .rise()
  );
  // Drive source select
  bdsc_edge_sync u_src (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pin(drive_source_sel),
    .level(src_s),
    .rise()
  );
  // Duty adjust select, its rise enters duty mode at any tap
  bdsc_edge_sync u_duty (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pin(duty_adjust_sel),
    .level(duty_s),
    .rise(duty_rise)
  );
  // Gate a, also the step strobe
  bdsc_edge_sync u_a (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pin(gate_input_a),
    .level(a_s),
    .rise(a_rise)
  );
  // Gate b, also the step direction
  bdsc_edge_sync u_b (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pin(gate_input_b),
    .level(b_s),
    .rise()
  );

  ////////////////////////////////////////////////////////////////
  // Period table in ref_clk cycles, one entry per tap
  // Built from constants, so it costs no divider in hardware
  wire [15:0] period_tab [0:NTAPS-1];
  genvar gi;
  generate
    for (gi = 0; gi < NTAPS; gi = gi + 1) begin : g_tap
      localparam integer PER_CYC = `BDSC_CLK_HZ / (F_MIN_HZ + gi * TAP_STEP_HZ);
      assign period_tab[gi] = PER_CYC[15:0]; // RULE19 RULE17
    end
  endgenerate

  // Present period; tap never passes TOP_TAP so the index stays in range
  wire [15:0] period = period_tab[tap];
  // High time scales with duty percent; 50% is half period
  // high_prod holds a period times a percent, 23 bits
  wire [22:0] high_prod = {7'h0, period} * {16'h0, duty};
  wire [22:0] high_div = high_prod / 23'd100;
  wire [15:0] high_len = high_div[15:0];
  wire [15:0] half_len = {1'b0, period[15:1]};

  ////////////////////////////////////////////////////////////////
  // Mode selection
  always @* begin
    next_state = state;
    if (!en_s) begin
      next_state = ST_OFF; // RULE20
    end else if (src_s) begin
      next_state = ST_DIRECT; // RULE1 RULE2
    end else if (state == ST_OFF || state == ST_DIRECT) begin
      next_state = ST_FREQ; // RULE1
    end else if (state == ST_FREQ && duty_s && (tap == TOP_TAP[4:0] || duty_rise)) begin
      next_state = ST_DUTY; // RULE10 RULE11
    end else if (state == ST_DUTY && !duty_s && duty == `BDSC_DUTY_MAX) begin
      next_state = ST_FREQ; // RULE16
    end
  end

  // Step decode shared by the tap and duty registers
  assign enter_self = (next_state == ST_FREQ) && (state == ST_OFF || state == ST_DIRECT);
  assign freq_move = (state == ST_FREQ) && (next_state == ST_FREQ) && a_rise;
  assign duty_move = (state == ST_DUTY) && a_rise;
  assign self_mode = (state == ST_FREQ) || (state == ST_DUTY);

  // Mode register
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // Tap register: restart at 175 kHz on entry, one tap per strobe
  // Strobes past either end are dropped
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tap <= 5'h0;
    end else if (enter_self) begin
      tap <= START_TAP[4:0]; // RULE6
    end else if (freq_move) begin
      if (!b_s && tap != TOP_TAP[4:0]) begin
        tap <= tap + 5'h1; // RULE5 RULE8
      end else if (b_s && tap != 5'h0) begin
        tap <= tap - 5'h1; // RULE9
      end
    end
  end

  // Duty register: pinned at 50% while stepping frequency
  // Strobes at a limit are dropped, so duty stays on the step grid
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      duty <= DUTY_MAX;
    end else if (enter_self) begin
      duty <= DUTY_MAX;
    end else if (freq_move) begin
      duty <= DUTY_MAX; // RULE18
    end else if (duty_move) begin
      if (!b_s && duty > DUTY_MIN) begin
        duty <= duty - DUTY_INC; // RULE12 RULE13
      end else if (b_s && duty < DUTY_MAX) begin
        duty <= duty + DUTY_INC; // RULE14 RULE15
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Phase counter; a shorter period after a tap change wraps at once
  // Counter width covers the slowest tap's period
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= 16'h0;
    end else if (!self_mode) begin
      phase <= 16'h0;
    end else if (phase >= period - 16'h1) begin
      phase <= 16'h0;
    end else begin
      phase <= phase + 16'h1;
    end
  end

  // Nodes: a high for high_len from phase zero, b the same half a period on
  // Registered so node a and the echo pipe start together
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      node_a <= 1'b0;
      node_b <= 1'b0;
    end else if (!self_mode) begin
      node_a <= 1'b0;
      node_b <= 1'b0;
    end else begin
      node_a <= (phase < high_len);
      node_b <= (phase >= half_len) && (phase < half_len + high_len);
    end
  end

  // Echo delayed by the drive path so its rise meets bridge_a_high's rise
  // Cleared at once on leaving self mode rather than left to drain
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      echo_pipe <= {ECHO_LAG{1'b0}};
      rate_echo <= 1'b0;
    end else if (!self_mode) begin
      echo_pipe <= {ECHO_LAG{1'b0}};
      rate_echo <= 1'b0;
    end else begin
      echo_pipe <= {echo_pipe[ECHO_LAG-2:0], phase < half_len}; // RULE7
      rate_echo <= echo_pipe[ECHO_LAG-1];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Drive source mux; direct mode needs four cycles of pulse
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_a <= 1'b0;
      drive_b <= 1'b0;
    end else if (state == ST_DIRECT) begin
      drive_a <= a_s; // RULE2 RULE4
      drive_b <= b_s;
    end else begin
      drive_a <= node_a;
      drive_b <= node_b;
    end
  end

  // Legs: dead time and enable gating live in the leg driver
  // Both legs share one enable so they switch off together
  assign leg_enable = (state != ST_OFF); // RULE20
  bdsc_leg_driver #(
    .DEAD_CYC(DEAD_CYC)
  ) u_leg_a (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .enable(leg_enable),
    .want_high(drive_a),
    .high_on(bridge_a_high),
    .low_on(bridge_a_low)
  );

  // Leg b: same timing, so node b keeps its half period offset
  bdsc_leg_driver #(
    .DEAD_CYC(DEAD_CYC)
  ) u_leg_b (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .enable(leg_enable),
    .want_high(drive_b),
    .high_on(bridge_b_high),
    .low_on(bridge_b_low)
  );
endmodule

// [logic/bdsc_consts.vh]
// Purpose: constants for the bridge drive step controller
// Assumes: 100 MHz ref_clk
// Notes: times in ns or Hz with derived cycle counts
`ifndef BDSC_CONSTS_VH
`define BDSC_CONSTS_VH
`define BDSC_CLK_HZ 100000000
`define BDSC_DEAD_NS 20
// Dead time, longest time, rounded down, at least one cycle
`define BDSC_DEAD_CYC ((`BDSC_DEAD_NS * 100) / 1000)
`define BDSC_F_START_HZ 175000
`define BDSC_F_MIN_HZ 110000
`define BDSC_F_MAX_HZ 205000
// Number of frequency taps and their step
`define BDSC_NTAPS 20
`define BDSC_TAP_STEP_HZ 5000
// Duty positions in percent
`define BDSC_DUTY_MIN 10
`define BDSC_DUTY_MAX 50
`define BDSC_DUTY_STEP 5
`endif

// [logic/bdsc_edge_sync.v]
// Purpose: two-flop synchroniser with rising edge pulse
// Assumes: input asynchronous to ref_clk
// Notes: edge detect reads only the second stage and beyond
`timescale 1ns/1ps
module bdsc_edge_sync (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Pin and results
  input wire pin,
  output wire level,
  output wire rise
);
  reg s1;
  reg s2;
  reg s3;

  // First stage feeds only the second
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign level = s2;
  assign rise = s2 & ~s3;
endmodule

// [logic/bdsc_leg_driver.v]
// Purpose: one bridge leg with dead time between switches
// Assumes: request is synchronous to ref_clk
// Notes: both switches off while enable is low
`timescale 1ns/1ps
module bdsc_leg_driver #(
  parameter DEAD_CYC = 2
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Control
  input wire enable,
  input wire want_high,
  // Gate outputs
  output reg high_on,
  output reg low_on
);
  reg [3:0] dead_cnt;
  reg state;

  // Break before make: each change passes a dead gap
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      high_on <= 1'b0;
      low_on <= 1'b0;
      dead_cnt <= 4'h0;
      state <= 1'b0;
    end else if (!enable) begin
      high_on <= 1'b0; // RULE20
      low_on <= 1'b0;
      dead_cnt <= DEAD_CYC[3:0];
      state <= 1'b0;
    end else if (want_high != state) begin
      high_on <= 1'b0; // RULE3
      low_on <= 1'b0;
      state <= want_high;
      dead_cnt <= DEAD_CYC[3:0];
    end else if (dead_cnt != 4'h0) begin
      dead_cnt <= dead_cnt - 4'h1;
    end else begin
      high_on <= state;
      low_on <= ~state;
    end
  end
endmodule

// [verification/bdsc_props.sv]
// Purpose: port checker for bdsc_top
// Assumes: bound from the bench top
// Notes: registered legs, two cycle dead time
`timescale 1ns/1ps
module bdsc_props (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Controller pins
  input wire enable,
  input wire drive_source_sel,
  input wire duty_adjust_sel,
  input wire gate_input_a,
  input wire gate_input_b,
  // Bridge and echo
  input wire bridge_a_high,
  input wire bridge_a_low,
  input wire bridge_b_high,
  input wire bridge_b_low,
  input wire rate_echo
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  // Overlap in a leg would short the supply
  leg_a_overlap_a: assert property (!(bridge_a_high && bridge_a_low)) else $error("leg a overlap");
  leg_b_overlap_a: assert property (!(bridge_b_high && bridge_b_low)) else $error("leg b overlap");
  dead_a_gap_a: assert property ($fell(bridge_a_low) |-> !bridge_a_high ##1 !bridge_a_high)
    else $error("leg a gap short");
  dead_b_gap_a: assert property ($fell(bridge_b_low) |-> !bridge_b_high ##1 !bridge_b_high)
    else $error("leg b gap short");
  // Sync and dead time fit inside eight cycles
  direct_a_pass_a: assert property ((enable && drive_source_sel && gate_input_a)[*8] |-> bridge_a_high)
    else $error("gate a not passed");
  direct_b_pass_a: assert property ((enable && drive_source_sel && !gate_input_b)[*8] |-> bridge_b_low)
    else $error("gate b not passed");
  off_all_low_a: assert property ((!enable)[*5] |-> !(bridge_a_high || bridge_a_low || bridge_b_high || bridge_b_low))
    else $error("switch on while off");
  echo_direct_low_a: assert property (drive_source_sel[*5] |-> !rate_echo) else $error("echo in direct");
  echo_node_align_a: assert property ($rose(rate_echo) |-> ##[0:3] bridge_a_high)
    else $error("echo not with node");
endmodule

// [verification/bdsc_ctrl_model.sv]
// Purpose: controller model driving mode and step pins
// Assumes: pins change on falling ref_clk edges
// Notes: strobe high phases of four cycles, with at least three low between, suit the synchroniser
`timescale 1ns/1ps
module bdsc_ctrl_model (
  // Clock
  input wire ref_clk,
  // Pins toward the device
  output reg enable,
  output reg drive_source_sel,
  output reg duty_adjust_sel,
  output reg gate_input_a,
  output reg gate_input_b
);
  ////////////////////////////////////////
  // Enabled direct drive, gates low, from time zero
  initial begin
    enable = 1'b1;
    drive_source_sel = 1'b1;
    duty_adjust_sel = 1'b0;
    gate_input_a = 1'b0;
    gate_input_b = 1'b0;
  end
  // Mode pins, then settle time
  task set(input reg en, input reg src, input reg duty);
    begin
      @(negedge ref_clk);
      enable = en;
      drive_source_sel = src;
      duty_adjust_sel = duty;
      repeat (5) @(negedge ref_clk);
    end
  endtask
  // Direction set a cycle ahead so it is stable at the strobe
  task strobe(input reg dir, input integer n);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) begin
        @(negedge ref_clk);
        gate_input_b = dir;
        @(negedge ref_clk);
        gate_input_a = 1'b1;
        repeat (4) @(negedge ref_clk);
        gate_input_a = 1'b0;
        repeat (3) @(negedge ref_clk);
      end
    end
  endtask
  // Direct gate levels, then held for n cycles
  task gates(input reg a, input reg b, input integer n);
    begin
      @(negedge ref_clk);
      gate_input_a = a;
      gate_input_b = b;
      repeat (n) @(negedge ref_clk);
    end
  endtask
endmodule

// [verification/bdsc_top_test.sv]
// Purpose: self-checking bench for bdsc_top
// Assumes: 100 MHz clock, default taps and duty steps
// Notes: periods measured in cycles with small tolerance
`timescale 1ns/1ps
module bdsc_top_test;
  reg ref_clk = 1'b0;
  reg rst_b = 1'b0;
  reg use_node = 1'b0;
  reg saw_a = 1'b0;
  wire enable, drive_source_sel, duty_adjust_sel, gate_input_a, gate_input_b;
  wire bridge_a_high, bridge_a_low, bridge_b_high, bridge_b_low, rate_echo;
  wire w = use_node ? bridge_a_high : rate_echo;
  integer fails = 0;
  integer comparisons = 0;
  integer cycles = 0;
  integer p, h;
  ////////////////////////////////////////
  always #5 ref_clk = ~ref_clk;
  bdsc_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .enable(enable), .drive_source_sel(drive_source_sel),
    .duty_adjust_sel(duty_adjust_sel), .gate_input_a(gate_input_a), .gate_input_b(gate_input_b),
    .bridge_a_high(bridge_a_high), .bridge_a_low(bridge_a_low), .bridge_b_high(bridge_b_high),
    .bridge_b_low(bridge_b_low), .rate_echo(rate_echo));
  bdsc_ctrl_model ctrl (.ref_clk(ref_clk), .enable(enable), .drive_source_sel(drive_source_sel),
    .duty_adjust_sel(duty_adjust_sel), .gate_input_a(gate_input_a), .gate_input_b(gate_input_b));
  // Sticky sight of bridge_a_high, and a hang limit
  always @(negedge ref_clk) if (bridge_a_high === 1'b1) saw_a = 1'b1;
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 60000) begin
      fails = fails + 1;
      wrap_up;
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Divider rounding is the designer's, so allow a little slack
  task near(input integer a, input integer b, input integer t);
    check((a - b <= t) && (b - a <= t), 1);
  endtask
  function integer per(input integer n);
    per = 100000000 / (110000 + 5000 * n);
  endfunction
  // Second full period, the first may straddle an update
  task measure;
    integer k;
    begin
      for (k = 0; k < 2; k = k + 1) begin
        while (w !== 1'b0) @(negedge ref_clk);
        while (w !== 1'b1) @(negedge ref_clk);
        for (h = 0; w === 1'b1; h = h + 1) @(negedge ref_clk);
        for (p = h; w === 1'b0; p = p + 1) @(negedge ref_clk);
      end
    end
  endtask
  task t_freq;
    begin
      ctrl.set(1'b1, 1'b0, 1'b0);
      measure;
      near(p, per(13), 1);
      near(h, p / 2, 1);
      ctrl.strobe(1'b0, 1);
      measure;
      near(p, per(14), 1);
      ctrl.strobe(1'b0, 6);
      measure;
      near(p, per(19), 1);
      ctrl.strobe(1'b1, 1);
      measure;
      near(p, per(18), 1);
    end
  endtask
  task t_duty;
    begin
      use_node = 1'b1;
      ctrl.set(1'b1, 1'b0, 1'b1);
      ctrl.strobe(1'b0, 1);
      measure;
      near(h, per(18) * 45 / 100, 4);
      ctrl.strobe(1'b1, 1);
      ctrl.set(1'b1, 1'b0, 1'b0);
      ctrl.strobe(1'b0, 1);
      ctrl.set(1'b1, 1'b0, 1'b1);
      measure;
      near(h, per(19) / 2, 4);
      ctrl.strobe(1'b0, 9);
      measure;
      near(h, per(19) / 10, 4);
      near(p, per(19), 1);
      ctrl.strobe(1'b1, 1);
      measure;
      near(h, per(19) * 15 / 100, 4);
      ctrl.strobe(1'b1, 8);
      measure;
      near(h, per(19) / 2, 4);
      ctrl.set(1'b1, 1'b0, 1'b0);
      ctrl.strobe(1'b1, 1);
      measure;
      near(p, per(18), 1);
      use_node = 1'b0;
    end
  endtask
  // A 40 ns gate pulse must still reach the bridge
  task t_direct;
    begin
      ctrl.set(1'b1, 1'b1, 1'b0);
      saw_a = 1'b0;
      ctrl.strobe(1'b0, 1);
      repeat (4) @(negedge ref_clk);
      check(saw_a, 1'b1);
      ctrl.gates(1'b1, 1'b0, 10);
      check({bridge_a_high, bridge_a_low, bridge_b_high, bridge_b_low}, 4'h9);
      ctrl.gates(1'b0, 1'b1, 10);
      check({bridge_a_high, bridge_a_low, bridge_b_high, bridge_b_low}, 4'h6);
      ctrl.set(1'b0, 1'b0, 1'b0);
      check({bridge_a_high, bridge_a_low, bridge_b_high, bridge_b_low}, 4'h0);
    end
  endtask
  task wrap_up;
    begin
      $display("Comparisons %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(negedge ref_clk);
    rst_b = 1'b1;
    t_freq;
    t_duty;
    t_direct;
    wrap_up;
  end
endmodule
bind bdsc_top bdsc_props chk (
  .ref_clk(ref_clk),
  .rst_b(rst_b),
  .enable(enable),
  .drive_source_sel(drive_source_sel),
  .duty_adjust_sel(duty_adjust_sel),
  .gate_input_a(gate_input_a),
  .gate_input_b(gate_input_b),
  .bridge_a_high(bridge_a_high),
  .bridge_a_low(bridge_a_low),
  .bridge_b_high(bridge_b_high),
  .bridge_b_low(bridge_b_low),
  .rate_echo(rate_echo)
);
